//--- pkg/asm_regs.svh
`ifndef ASM_REGS_SVH
`define ASM_REGS_SVH

// Register offsets on the configuration port
`define ASM_ALARM_OFS      12'h2c0
`define ASM_STATUS_OFS     12'h2c1
`define ASM_MASK_OFS       12'h2c2

// Field positions shared by status and mask
`define ASM_POS_PLL        4
`define ASM_POS_LINK       3
`define ASM_POS_REALIGN    2
`define ASM_POS_OSC        1
`define ASM_POS_DIV        0
`define ASM_RSVD_LO        5
`define ASM_RSVD_HI        7
`define ASM_NUM_ALARMS     5

// Reset values
`define ASM_STATUS_RESET   5'h1f
`define ASM_MASK_RESET     8'h1f
`define ASM_RSVD_RESET     3'h0

`endif

//--- pkg/asm_pkg.sv
package asm_pkg;

  // Alarm causes in status bit order, bit 4 down to bit 0
  typedef struct packed {
    logic pll_unlock;
    logic link_not_running;
    logic clock_realign;
    logic oscillator_fault;
    logic divider_mismatch;
  } asm_cause_t;

  typedef logic [7:0] asm_byte_t;

endpackage

//--- verilog/asm_flag_cell.sv
`timescale 1ns/1ps
`default_nettype none

// One sticky alarm flag; a set in the clear cycle wins
module asm_flag_cell #(
  parameter logic RESET_VAL = 1'b1
) (
  input  wire logic clk,
  input  wire logic rst_n,
  input  wire logic set,
  input  wire logic clr,
  output logic      flag
);

  logic flag_q;
  logic flag_d;

  // Cause has priority so no event is lost during a clear
  assign flag_d = set | (flag_q & ~clr);
  assign flag   = flag_q;

  always_ff @(posedge clk or negedge rst_n) begin
    if (!rst_n) begin
      flag_q <= RESET_VAL;
    end else begin
      flag_q <= flag_d;
    end
  end

endmodule

`default_nettype wire

//--- verilog/asm_alarm_status_mask.sv
`timescale 1ns/1ps
`default_nettype none
`include "asm_regs.svh"

// Overview of operation
// - PLL out of lock sets status bit 4
// - Writing one clears that status flag
// - Link enabled, not in data: bit 3
// - Clock realignment by SYSREF sets bit 2
// - Channel divider mismatch sets bit 0
// - Mask resets to all five bits set
// - Set mask bits 4,3,2,0 exclude alarms
// - Mask bit 1 excludes oscillator alarm
// - Summary bit reads one on unmasked alarm
// - Summary drives status pin when selected
module asm_alarm_status_mask #(
  parameter int DIV_W = 4
) (
  input  wire logic             CLK,
  input  wire logic             NRST,
  input  wire logic [11:0]      REG_ADDR,
  input  wire logic             REG_WR,
  input  wire logic             REG_RD,
  input  wire logic [7:0]       REG_WDATA,
  output logic      [7:0]       REG_RDATA,
  input  wire logic             PLL_LOCKED,
  input  wire logic             LINK_EN,
  input  wire logic             DATA_PHASE_STATE,
  input  wire logic             SYSREF_REALIGN,
  input  wire logic             OSC_FAULT,
  input  wire logic [DIV_W-1:0] DIV_PHASE_A,
  input  wire logic [DIV_W-1:0] DIV_PHASE_B,
  input  wire logic             STATUS_SEL,
  output logic                  ALARM_SUMMARY,
  output logic                  STATUS_OUT_PIN
);

  logic                        rst_meta_q;
  logic                        rst_n;
  asm_pkg::asm_cause_t         cause;
  logic [`ASM_NUM_ALARMS-1:0]  cause_vec;
  logic [`ASM_NUM_ALARMS-1:0]  clr_vec;
  logic [`ASM_NUM_ALARMS-1:0]  flags;
  logic [`ASM_NUM_ALARMS-1:0]  unmasked;
  asm_pkg::asm_byte_t          mask_q;
  logic [2:0]                  rsvd_q;
  logic                        wr_status;
  logic                        wr_mask;
  logic                        summary;
  logic                        alarm_q;
  logic                        pin_q;
  asm_pkg::asm_byte_t          rdata_q;
  asm_pkg::asm_byte_t          rdata_d;
  asm_pkg::asm_byte_t          status_rd;
  // Per-bit reset values, sliced per cell rather than shifted and truncated
  localparam logic [`ASM_NUM_ALARMS-1:0] status_rst_val = `ASM_STATUS_RESET;

  // Reset is released through two flops so all flops behind them leave reset together
  always_ff @(posedge CLK or negedge NRST) begin
    if (!NRST) begin
      rst_meta_q <= 1'b0;
      rst_n      <= 1'b0;
    end else begin
      rst_meta_q <= 1'b1;
      rst_n      <= rst_meta_q;
    end
  end

  // Alarm causes, sampled as levels every cycle
  assign cause.pll_unlock       = ~PLL_LOCKED;
  assign cause.link_not_running = LINK_EN & ~DATA_PHASE_STATE;
  assign cause.clock_realign    = SYSREF_REALIGN;
  assign cause.oscillator_fault = OSC_FAULT;
  assign cause.divider_mismatch = (DIV_PHASE_A != DIV_PHASE_B);
  assign cause_vec              = cause;

  // Register write decode
  assign wr_status = REG_WR & (REG_ADDR == `ASM_STATUS_OFS);
  assign wr_mask   = REG_WR & (REG_ADDR == `ASM_MASK_OFS);
  // Only ones clear; zeros leave flags alone
  assign clr_vec   = wr_status ? REG_WDATA[`ASM_NUM_ALARMS-1:0]
                               : '0;

  // One sticky cell per alarm bit
  genvar gi;
  generate
    for (gi = 0; gi < `ASM_NUM_ALARMS; gi++) begin : g_flag
      asm_flag_cell #(
        .RESET_VAL (status_rst_val[gi])
      ) u_flag (
        .clk   (CLK),
        .rst_n (rst_n),
        .set   (cause_vec[gi]),
        .clr   (clr_vec[gi]),
        .flag  (flags[gi])
      );
    end
  endgenerate

  // Mask gates each flag; bit 1 covers the oscillator alarm
  assign unmasked = flags & ~mask_q[`ASM_NUM_ALARMS-1:0];
  assign summary  = |unmasked;

  // Mask and reserved storage; reserved bits never reach the summary
  always_ff @(posedge CLK or negedge rst_n) begin
    if (!rst_n) begin
      mask_q <= `ASM_MASK_RESET;
      rsvd_q <= `ASM_RSVD_RESET;
    end else begin
      if (wr_mask) begin
        mask_q <= REG_WDATA;
      end
      if (wr_status) begin
        rsvd_q <= REG_WDATA[`ASM_RSVD_HI:`ASM_RSVD_LO];
      end
    end
  end

  // Read mux; unmapped addresses answer zero
  assign status_rd = {rsvd_q, flags};
  assign rdata_d   = (REG_ADDR == `ASM_ALARM_OFS)  ? {7'h00, summary} :
                     (REG_ADDR == `ASM_STATUS_OFS) ? status_rd :
                     (REG_ADDR == `ASM_MASK_OFS)   ? mask_q : 8'h00;

  // Registered read data and outputs; the pin is glitch-free this way
  always_ff @(posedge CLK or negedge rst_n) begin
    if (!rst_n) begin
      rdata_q <= 8'h00;
      alarm_q <= 1'b0;
      pin_q   <= 1'b0;
    end else begin
      if (REG_RD) begin
        rdata_q <= rdata_d;
      end
      alarm_q <= summary;
      pin_q   <= STATUS_SEL & summary;
    end
  end

  assign REG_RDATA      = rdata_q;
  assign ALARM_SUMMARY  = alarm_q;
  assign STATUS_OUT_PIN = pin_q;

  // Checks next to the logic they guard
  AST_PLL_SET: assert property (@(posedge CLK) disable iff (!rst_n)
    !PLL_LOCKED |=> flags[`ASM_POS_PLL])
    else $error("PLL unlock flag not set");

  AST_W1C_CLEAR: assert property (@(posedge CLK) disable iff (!rst_n)
    (wr_status && REG_WDATA[`ASM_POS_LINK] && !cause.link_not_running)
    |=> !flags[`ASM_POS_LINK])
    else $error("Write one did not clear link flag");

  AST_LINK_SET: assert property (@(posedge CLK) disable iff (!rst_n)
    (LINK_EN && !DATA_PHASE_STATE) |=> flags[`ASM_POS_LINK])
    else $error("Link flag not set");

  AST_REALIGN_SET: assert property (@(posedge CLK) disable iff (!rst_n)
    SYSREF_REALIGN |=> flags[`ASM_POS_REALIGN])
    else $error("Realign flag not set");

  AST_DIV_SET: assert property (@(posedge CLK) disable iff (!rst_n)
    (DIV_PHASE_A != DIV_PHASE_B) |=> flags[`ASM_POS_DIV])
    else $error("Divider mismatch flag not set");

  AST_MASK_RESET: assert property (@(posedge CLK) disable iff (!rst_n)
    $rose(rst_n) |-> (mask_q == `ASM_MASK_RESET))
    else $error("Mask not at reset value after reset");

  AST_ALL_MASKED: assert property (@(posedge CLK) disable iff (!rst_n)
    (mask_q[4:0] == 5'h1f) |=> !ALARM_SUMMARY)
    else $error("Summary set while all alarms masked");

  AST_OSC_MASKED: assert property (@(posedge CLK) disable iff (!rst_n)
    (mask_q[`ASM_POS_OSC] && ((flags & ~mask_q[4:0] & 5'h1d) == 5'h00))
    |=> !ALARM_SUMMARY)
    else $error("Masked oscillator alarm reached summary");

  AST_SUMMARY_READ: assert property (@(posedge CLK) disable iff (!rst_n)
    (REG_RD && REG_ADDR == `ASM_ALARM_OFS && (flags & ~mask_q[4:0]) != 0)
    |=> REG_RDATA == 8'h01)
    else $error("Summary read did not return one");

  AST_PIN_DRIVE: assert property (@(posedge CLK) disable iff (!rst_n)
    (STATUS_SEL && summary) |=> STATUS_OUT_PIN ##0 ALARM_SUMMARY)
    else $error("Status pin not driven by summary");

  AST_STICKY: assert property (@(posedge CLK) disable iff (!rst_n)
    (flags[`ASM_POS_PLL] && !(wr_status && REG_WDATA[`ASM_POS_PLL]))
    |=> flags[`ASM_POS_PLL])
    else $error("PLL flag dropped without a clear");

  AST_RSVD_READBACK: assert property (@(posedge CLK) disable iff (!rst_n)
    (wr_status ##1 (REG_RD && REG_ADDR == `ASM_STATUS_OFS && !REG_WR))
    |=> REG_RDATA[7:5] == $past(REG_WDATA[7:5], 2))
    else $error("Reserved status bits not read back");

  AST_W1C_DIV: assert property (@(posedge CLK) disable iff (!rst_n)
    (wr_status && REG_WDATA[`ASM_POS_DIV] && !cause.divider_mismatch)
    |=> !flags[`ASM_POS_DIV])
    else $error("Write one did not clear divider flag");

  AST_W1C_REALIGN: assert property (@(posedge CLK) disable iff (!rst_n)
    (wr_status && REG_WDATA[`ASM_POS_REALIGN] && !SYSREF_REALIGN)
    |=> !flags[`ASM_POS_REALIGN])
    else $error("Write one did not clear realign flag");

  AST_ZERO_KEEPS: assert property (@(posedge CLK) disable iff (!rst_n)
    (wr_status && !REG_WDATA[`ASM_POS_DIV] && flags[`ASM_POS_DIV])
    |=> flags[`ASM_POS_DIV])
    else $error("Write zero dropped divider flag");

  AST_SUMMARY_SET: assert property (@(posedge CLK) disable iff (!rst_n)
    ((flags & ~mask_q[`ASM_NUM_ALARMS-1:0]) != 5'h00) |=> ALARM_SUMMARY)
    else $error("Unmasked alarm missing from summary");

  AST_SUMMARY_CLEAR: assert property (@(posedge CLK) disable iff (!rst_n)
    ((flags & ~mask_q[`ASM_NUM_ALARMS-1:0]) == 5'h00) |=> !ALARM_SUMMARY)
    else $error("Summary set with no unmasked alarm");

  AST_PIN_OFF: assert property (@(posedge CLK) disable iff (!rst_n)
    !STATUS_SEL |=> !STATUS_OUT_PIN)
    else $error("Status pin driven while not selected");

  AST_MASK_WRITE: assert property (@(posedge CLK) disable iff (!rst_n)
    wr_mask |=> mask_q == $past(REG_WDATA))
    else $error("Mask write not stored");

  AST_RSVD_NO_EFFECT: assert property (@(posedge CLK) disable iff (!rst_n)
    (mask_q[`ASM_RSVD_HI:`ASM_RSVD_LO] != 3'h0 && mask_q[4:0] == 5'h1f)
    |=> !STATUS_OUT_PIN)
    else $error("Reserved mask bits reached the status pin");

endmodule

`default_nettype wire

//--- tb/asm_alarm_status_mask_bench.sv
`timescale 1ns/1ps
`default_nettype none
`include "asm_regs.svh"
`define CHK(n, e, g) begin cmp_count++; if ((g) !== (e)) begin \
  mismatches++; $display("CHECK FAILED %s exp %h got %h", n, e, g); end end

// Bench drives all inputs at the falling edge; no open-ended waits
module asm_alarm_status_mask_bench;
  logic        CLK, NRST, REG_WR, REG_RD, PLL_LOCKED, LINK_EN;
  logic        DATA_PHASE_STATE, SYSREF_REALIGN, OSC_FAULT, STATUS_SEL;
  logic        ALARM_SUMMARY, STATUS_OUT_PIN;
  logic [11:0] REG_ADDR;
  logic [7:0]  REG_WDATA, REG_RDATA;
  logic [3:0]  DIV_PHASE_A, DIV_PHASE_B;
  int          mismatches = 0;
  int          cmp_count = 0;

  asm_alarm_status_mask i_dut (.CLK(CLK), .NRST(NRST),
    .REG_ADDR(REG_ADDR), .REG_WR(REG_WR), .REG_RD(REG_RD),
    .REG_WDATA(REG_WDATA), .REG_RDATA(REG_RDATA),
    .PLL_LOCKED(PLL_LOCKED), .LINK_EN(LINK_EN),
    .DATA_PHASE_STATE(DATA_PHASE_STATE), .SYSREF_REALIGN(SYSREF_REALIGN),
    .OSC_FAULT(OSC_FAULT), .DIV_PHASE_A(DIV_PHASE_A),
    .DIV_PHASE_B(DIV_PHASE_B), .STATUS_SEL(STATUS_SEL),
    .ALARM_SUMMARY(ALARM_SUMMARY), .STATUS_OUT_PIN(STATUS_OUT_PIN));

  // 40 MHz clock
  initial begin
    CLK = 1'b0;
    forever #12.5 CLK = ~CLK;
  end

  // One-cycle write strobe
  task automatic wr(input logic [11:0] a, input logic [7:0] d);
    REG_ADDR = a;
    REG_WDATA = d;
    REG_WR = 1'b1;
    @(negedge CLK);
    REG_WR = 1'b0;
  endtask

  // Read data is registered, so it is checked a full cycle later
  task automatic rd(input logic [11:0] a, input logic [7:0] e, input string n);
    REG_ADDR = a;
    REG_RD = 1'b1;
    @(negedge CLK);
    REG_RD = 1'b0;
    @(negedge CLK);
    `CHK(n, e, REG_RDATA)
  endtask

  // Raise or drop the cause behind one status bit
  task automatic cause(input int b, input logic on);
    case (b)
      4: PLL_LOCKED = !on;
      3: LINK_EN = on;
      2: SYSREF_REALIGN = on;
      1: OSC_FAULT = on;
      default: DIV_PHASE_B = on ? 4'h5 : 4'h0;
    endcase
  endtask

  task automatic summarize;
    if (mismatches == 0 && cmp_count > 0) begin
      $display("[ PASS ]");
    end else begin
      $display("[ FAIL ]");
    end
    $finish;
  endtask

  // Main sequence; first access waits out the reset synchroniser
  initial begin
    {NRST, REG_WR, REG_RD, LINK_EN, DATA_PHASE_STATE} = '0;
    {SYSREF_REALIGN, OSC_FAULT, STATUS_SEL} = '0;
    PLL_LOCKED = 1'b1;
    REG_ADDR = 12'h000;
    REG_WDATA = 8'h00;
    DIV_PHASE_A = 4'h0;
    DIV_PHASE_B = 4'h0;
    repeat (4) @(negedge CLK);
    NRST = 1'b1;
    repeat (3) @(negedge CLK);
    rd(`ASM_STATUS_OFS, 8'h1f, "status_rst");
    rd(`ASM_MASK_OFS, 8'h1f, "mask_rst");
    rd(`ASM_ALARM_OFS, 8'h00, "summary_rst");
    wr(`ASM_STATUS_OFS, 8'h1f);
    rd(`ASM_STATUS_OFS, 8'h00, "status_clr");
    // Each alarm: brief cause, sticky flag, masked, unmasked, cleared
    for (int b = 4; b >= 0; b--) begin
      STATUS_SEL = b[0];
      cause(b, 1'b1);
      @(negedge CLK);
      cause(b, 1'b0);
      repeat (2) @(negedge CLK);
      `CHK("summary_masked", 1'b0, ALARM_SUMMARY)
      wr(`ASM_STATUS_OFS, 8'h00);
      rd(`ASM_STATUS_OFS, 8'h01 << b, "status_set");
      wr(`ASM_MASK_OFS, ~(8'h01 << b) & 8'h1f);
      repeat (2) @(negedge CLK);
      `CHK("summary", 1'b1, ALARM_SUMMARY)
      `CHK("pin", b[0], STATUS_OUT_PIN)
      rd(`ASM_ALARM_OFS, 8'h01, "summary_rd");
      wr(`ASM_STATUS_OFS, 8'h01 << b);
      repeat (2) @(negedge CLK);
      `CHK("summary_clr", 1'b0, ALARM_SUMMARY)
      wr(`ASM_MASK_OFS, 8'h1f);
    end
    // Link in data state raises nothing
    LINK_EN = 1'b1;
    DATA_PHASE_STATE = 1'b1;
    repeat (2) @(negedge CLK);
    rd(`ASM_STATUS_OFS, 8'h00, "link_data");
    // A clear loses against a cause still present
    PLL_LOCKED = 1'b0;
    // Let the flag set first, so the clear really meets a live cause
    @(negedge CLK);
    wr(`ASM_STATUS_OFS, 8'h10);
    rd(`ASM_STATUS_OFS, 8'h10, "set_wins");
    wr(`ASM_STATUS_OFS, 8'he0);
    rd(`ASM_STATUS_OFS, 8'hf0, "status_rsvd");
    wr(`ASM_MASK_OFS, 8'he0);
    rd(`ASM_MASK_OFS, 8'he0, "mask_rsvd");
    `CHK("summary_rsvd", 1'b1, ALARM_SUMMARY)
    wr(`ASM_MASK_OFS, 8'hff);
    repeat (2) @(negedge CLK);
    `CHK("summary_all_masked", 1'b0, ALARM_SUMMARY)
    // Unmapped and read-only places
    rd(12'h123, 8'h00, "unmapped");
    wr(`ASM_ALARM_OFS, 8'hff);
    rd(`ASM_STATUS_OFS, 8'hf0, "status_kept");
    summarize();
  end
endmodule
`default_nettype wire
